// ---- core/scd_pkg.sv ----
package scd_pkg;
  // =====================================================
  // register map
  localparam logic [7:0] SCD_ADDR_CLK_DIV_CTRL = 8'hc7;
  localparam logic [7:0] SCD_ADDR_WAKE_EN = 8'hcb;
  localparam logic [7:0] SCD_CLK_DIV_CTRL_RST = 8'h00;
  localparam logic [7:0] SCD_WAKE_EN_RST = 8'h00;
  localparam logic [2:0] SCD_DIV_SEL_RST = 3'h0;
  localparam int SCD_MODE_LSB = 4;
  localparam int SCD_WAKE_WDT_BIT = 2;
  localparam int SCD_WAKE_EX1_BIT = 1;
  localparam int SCD_WAKE_EX0_BIT = 0;
  localparam logic [1:0] SCD_MODE_NORMAL = 2'h0;
  localparam logic [1:0] SCD_MODE_IMMED = 2'h1;
  localparam logic [1:0] SCD_MODE_DELAY = 2'h2;
  localparam logic [1:0] SCD_MODE_MANUAL = 2'h3;
  localparam int SCD_CNT_W = 12;
  localparam int SCD_MAX_DIV = 4096;

  typedef enum logic [2:0] {
    SCD_ST_NORMAL = 3'b000,
    SCD_ST_IMMED = 3'b001,
    SCD_ST_DLY_WAIT = 3'b010,
    SCD_ST_DLY_DIV = 3'b011,
    SCD_ST_DLY_WAKE = 3'b100,
    SCD_ST_MANUAL = 3'b101
  } scd_state_t;
endpackage

// ---- core/scd_clk_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// divided clock generator: while dividing, output only changes when the
// counter wraps, so no shortened phase reaches the core
module scd_clk_gen import scd_pkg::*; #(
  parameter int CNT_W = SCD_CNT_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic divide_in,
  input wire logic [2:0] div_sel_in,
  output logic core_clk_en_out,
  output logic core_clk_out
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] half_w;
  logic ph_reg;
  logic wrap_w;
  logic div_act_reg;

  // half period minus one per divisor code
  assign half_w = (div_sel_in == 3'h0) ? 12'h000 :
                  (div_sel_in == 3'h1) ? 12'h001 :
                  (div_sel_in == 3'h2) ? 12'h003 :
                  (div_sel_in == 3'h3) ? 12'h007 :
                  (div_sel_in == 3'h4) ? 12'h00f :
                  (div_sel_in == 3'h5) ? 12'h1ff :
                  (div_sel_in == 3'h6) ? 12'h3ff : 12'h7ff;
  assign wrap_w = (cnt_reg >= half_w);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      ph_reg <= 1'b0;
      div_act_reg <= 1'b0;
    end else begin
      cnt_reg <= (wrap_w || !div_act_reg) ? '0 : cnt_reg + 12'h001;
      if (!div_act_reg || wrap_w)
        ph_reg <= !ph_reg;
      // mode switch only at the end of a high phase
      if (ph_reg && (wrap_w || !div_act_reg))
        div_act_reg <= divide_in;
    end
  end

  // enable form of the divided clock: one pulse per core cycle
  assign core_clk_en_out = !div_act_reg || (wrap_w && ph_reg);
  assign core_clk_out = ph_reg;
endmodule
`default_nettype wire

// ---- core/scd_top.sv ----
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module scd_top import scd_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic ms_tick_in,
  input wire logic ms_overflow_in,
  input wire logic millisecond_tick_interrupt_in,
  input wire logic wdt_irq_in,
  input wire logic ext_irq0_in,
  input wire logic ext_irq1_in,
  input wire logic [8:0] aux_irq_in,
  input wire logic aux_interrupt_enable_in,
  output logic idle_wake_out,
  output logic divide_active_out,
  output logic core_clk_en_out,
  output logic core_clk_out
);
  // =====================================================
  // register decode
  logic [2:0] div_sel_reg;
  logic [2:0] wake_en_reg;
  logic [7:0] rdata_reg;
  scd_state_t state_reg;
  scd_state_t state_next;
  logic wr_ctrl_w;
  logic wr_wake_w;
  logic [1:0] wmode_w;
  logic [1:0] mode_rd_w;
  logic [7:0] rd_mux_w;

  assign wr_ctrl_w = wr_in && (addr_in == SCD_ADDR_CLK_DIV_CTRL);
  assign wr_wake_w = wr_in && (addr_in == SCD_ADDR_WAKE_EN);
  assign wmode_w = wdata_in[SCD_MODE_LSB+1:SCD_MODE_LSB];

  // =====================================================
  // external interrupt pins: two flops before any logic reads them
  logic [1:0] ext0_sync_reg;
  logic [1:0] ext1_sync_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext0_sync_reg <= 2'h0;
      ext1_sync_reg <= 2'h0;
    end else begin
      ext0_sync_reg <= {ext0_sync_reg[0], ext_irq0_in};
      ext1_sync_reg <= {ext1_sync_reg[0], ext_irq1_in};
    end
  end

  // =====================================================
  // wake condition
  logic wake_w;
  assign wake_w = (wake_en_reg[SCD_WAKE_WDT_BIT] && wdt_irq_in) ||
                  (wake_en_reg[SCD_WAKE_EX1_BIT] && ext1_sync_reg[1]) ||
                  (wake_en_reg[SCD_WAKE_EX0_BIT] && ext0_sync_reg[1]) ||
                  (aux_interrupt_enable_in && (|aux_irq_in));
  assign idle_wake_out = wake_w;

  // =====================================================
  // divide mode state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SCD_ST_NORMAL: ;
      SCD_ST_IMMED: if (wake_w) state_next = SCD_ST_NORMAL;
      SCD_ST_DLY_WAIT: if (ms_tick_in) state_next = SCD_ST_DLY_DIV;
      SCD_ST_DLY_DIV: begin
        if (millisecond_tick_interrupt_in && ms_tick_in)
          state_next = SCD_ST_NORMAL;
        else if (!millisecond_tick_interrupt_in && wake_w)
          state_next = SCD_ST_DLY_WAKE;
      end
      SCD_ST_DLY_WAKE: if (ms_overflow_in) state_next = SCD_ST_NORMAL;
      SCD_ST_MANUAL: ;
      default: state_next = SCD_ST_NORMAL;
    endcase
    // any mode write restarts the machine; normal write ends division
    if (wr_ctrl_w) begin
      unique case (wmode_w)
        SCD_MODE_NORMAL: state_next = SCD_ST_NORMAL;
        SCD_MODE_IMMED: state_next = SCD_ST_IMMED;
        SCD_MODE_DELAY: state_next = SCD_ST_DLY_WAIT;
        SCD_MODE_MANUAL: state_next = SCD_ST_MANUAL;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in)
      state_reg <= SCD_ST_NORMAL;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_sel_reg <= SCD_DIV_SEL_RST;
      wake_en_reg <= SCD_WAKE_EN_RST[2:0];
    end else begin
      if (wr_ctrl_w)
        div_sel_reg <= wdata_in[2:0];
      if (wr_wake_w)
        wake_en_reg <= wdata_in[2:0];
    end
  end

  // =====================================================
  // readback: live state, not the written mode
  logic divide_w;
  assign divide_w = (state_reg == SCD_ST_IMMED) ||
                    (state_reg == SCD_ST_DLY_DIV) ||
                    (state_reg == SCD_ST_DLY_WAKE) ||
                    (state_reg == SCD_ST_MANUAL);
  // manual mode reports as no-delay immediate division since 11 is reserved
  assign mode_rd_w = (state_reg == SCD_ST_IMMED ||
                      state_reg == SCD_ST_MANUAL) ? SCD_MODE_IMMED :
                     (state_reg == SCD_ST_DLY_DIV ||
                      state_reg == SCD_ST_DLY_WAKE) ? SCD_MODE_DELAY :
                     SCD_MODE_NORMAL;
  assign rd_mux_w = (addr_in == SCD_ADDR_CLK_DIV_CTRL) ?
                      {2'h0, mode_rd_w, 1'b0, div_sel_reg} :
                    (addr_in == SCD_ADDR_WAKE_EN) ?
                      {5'h00, wake_en_reg} : 8'h00;

  always_ff @(posedge clk_in) begin
    if (rst_in)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rd_in ? rd_mux_w : 8'h00;
  end
  assign rdata_out = rdata_reg;
  assign divide_active_out = divide_w;

  // =====================================================
  // clock generator
  scd_clk_gen #(.CNT_W(SCD_CNT_W)) u_clk_gen (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .divide_in(divide_w),
    .div_sel_in(div_sel_reg),
    .core_clk_en_out(core_clk_en_out),
    .core_clk_out(core_clk_out)
  );

  // =====================================================
  // cycles spent in normal state; the clock generator may need a
  // full slow period to reach its switch point, so count past it
  logic [12:0] norm_cnt_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in)
      norm_cnt_reg <= 13'h0000;
    else if (state_reg != SCD_ST_NORMAL)
      norm_cnt_reg <= 13'h0000;
    else if (norm_cnt_reg != 13'h1fff)
      norm_cnt_reg <= norm_cnt_reg + 13'h0001;
  end

  // =====================================================
  // checks
  a_immed_wake_ends: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == SCD_ST_IMMED && wake_w && !wr_ctrl_w)
      |=> state_reg == SCD_ST_NORMAL)
    else $error("immediate mode did not end on wake");
  a_manual_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == SCD_ST_MANUAL && !wr_ctrl_w) |=> state_reg == SCD_ST_MANUAL)
    else $error("manual mode left without a write");
  a_normal_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_ctrl_w && wmode_w == SCD_MODE_NORMAL) |=> !divide_active_out)
    else $error("normal write did not end division");
  a_dly_start_tick: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == SCD_ST_DLY_WAIT && !ms_tick_in && !wr_ctrl_w)
      |=> !divide_active_out)
    else $error("delay mode divided before tick");
  a_dly_tick_end: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == SCD_ST_DLY_DIV && ms_tick_in &&
     millisecond_tick_interrupt_in && !wr_ctrl_w) |=> mode_rd_w == 2'h0)
    else $error("delay mode did not end on tick");
  a_masked_overflow: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == SCD_ST_DLY_WAKE && ms_overflow_in && !wr_ctrl_w)
      |=> !divide_active_out)
    else $error("masked delay mode missed overflow");
  a_read_delay: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == SCD_ADDR_WAKE_EN)
      |=> rdata_out == {5'h00, $past(wake_en_reg)})
    else $error("wake enable readback wrong");
  a_wake_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    (wake_en_reg == 3'h0 && !aux_interrupt_enable_in) |-> !idle_wake_out)
    else $error("wake raised with all enables clear");
  a_undiv_en: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == SCD_ST_NORMAL && norm_cnt_reg > 13'h1002)
      |-> core_clk_en_out)
    else $error("core clock divided in normal mode");
endmodule
`default_nettype wire

// ---- dv/scd_ms_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====================================
// millisecond timer beside the divider: free-running tick,
// overflow on every fourth tick, so exit times are known
module scd_ms_timer #(parameter int PERIOD = 40) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out,
  output logic ovf_out
);
  int cnt_reg;
  logic [1:0] ticks_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= 0;
      ticks_reg <= 2'h0;
    end else begin
      cnt_reg <= tick_out ? 0 : cnt_reg + 1;
      if (tick_out) ticks_reg <= ticks_reg + 2'h1;
    end
  end
  assign tick_out = (cnt_reg == PERIOD - 1);
  assign ovf_out = tick_out && (ticks_reg == 2'h3);
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scd_pkg::*;
  localparam int MS = 40;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic tick_en = 1'b0, wdt = 1'b0, ex0 = 1'b0, ex1 = 1'b0;
  logic [8:0] aux = 9'h000;
  logic aux_en = 1'b0;
  logic tick, ovf, wake, div_act, clk_en, clk_out;
  int num_errors = 0, check_count = 0, seed = 32'h5b6d;
  int m_mode = 0, m_div = 0, n, r;
  int divs[8] = '{2, 4, 8, 16, 32, 1024, 2048, 4096};
  always #12.5 clk_in = ~clk_in;
  scd_ms_timer #(.PERIOD(MS)) timer (.clk_in(clk_in), .rst_in(rst_in),
    .tick_out(tick), .ovf_out(ovf));
  scd_top dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ms_tick_in(tick), .ms_overflow_in(ovf),
    .millisecond_tick_interrupt_in(tick_en), .wdt_irq_in(wdt),
    .ext_irq0_in(ex0), .ext_irq1_in(ex1), .aux_irq_in(aux),
    .aux_interrupt_enable_in(aux_en), .idle_wake_out(wake),
    .divide_active_out(div_act), .core_clk_en_out(clk_en),
    .core_clk_out(clk_out));
  // =====================================
  // checking and bus tasks
  task automatic results();
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ctrl();
    return {2'b00, m_mode[1:0], 1'b0, m_div[2:0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  // bounded waits: a stuck divider ends the run instead of hanging
  task automatic wait_div(input logic v, input int lim);
    #1 n = 0;
    while (div_act !== v) begin
      @(posedge clk_in);
      #1 n++;
      if (n > lim) begin
        num_errors++;
        results();
      end
    end
  endtask
  task automatic pulse();
    n = 0;
    do begin
      @(posedge clk_in);
      #1 n++;
    end while (clk_en !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      num_errors++;
      results();
    end
  endtask
  // =====================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(SCD_ADDR_CLK_DIV_CTRL, 8'h00);
    rd(SCD_ADDR_WAKE_EN, 8'h00);
    rd(8'h55, 8'h00);
    chk(clk_en, 1'b1);
    wr(SCD_ADDR_CLK_DIV_CTRL, 8'hd9);
    m_mode = 1;
    m_div = 1;
    rd(SCD_ADDR_CLK_DIV_CTRL, ctrl());
    chk(div_act, 1'b1);
    wr(SCD_ADDR_WAKE_EN, 8'h01);
    ex0 <= 1'b1;
    wait_div(1'b0, 4);
    m_mode = 0;
    rd(SCD_ADDR_CLK_DIV_CTRL, ctrl());
    wr(SCD_ADDR_CLK_DIV_CTRL, 8'h31);
    repeat (5) @(posedge clk_in);
    #1 chk(div_act, 1'b1);
    m_mode = 1;
    rd(SCD_ADDR_CLK_DIV_CTRL, ctrl());
    ex0 <= 1'b0;
    wr(SCD_ADDR_CLK_DIV_CTRL, 8'h00);
    wait_div(1'b0, 2);
    tick_en <= 1'b1;
    wr(SCD_ADDR_CLK_DIV_CTRL, 8'h20);
    wait_div(1'b1, MS + 2);
    wait_div(1'b0, MS + 2);
    chk(n[15:0], MS);
    tick_en <= 1'b0;
    wr(SCD_ADDR_CLK_DIV_CTRL, 8'h20);
    wait_div(1'b1, MS + 2);
    m_mode = 2;
    m_div = 0;
    rd(SCD_ADDR_CLK_DIV_CTRL, ctrl());
    repeat (MS + 5) @(posedge clk_in);
    #1 chk(div_act, 1'b1);
    wr(SCD_ADDR_CLK_DIV_CTRL, 8'h00);
    wait_div(1'b0, 2);
    wr(SCD_ADDR_CLK_DIV_CTRL, 8'h20);
    wait_div(1'b1, MS + 2);
    ex0 <= 1'b1;
    @(posedge clk_in);
    ex0 <= 1'b0;
    wait_div(1'b0, 4 * MS + 2);
    // third pulse gap only: the first after a switch may be partial
    for (int i = 0; i < 8; i++) begin
      wr(SCD_ADDR_CLK_DIV_CTRL, 8'h30 | i[7:0]);
      pulse();
      pulse();
      pulse();
      chk(n[15:0], divs[i][15:0]);
      chk(clk_out, 1'b1);
    end
    wr(SCD_ADDR_CLK_DIV_CTRL, 8'h00);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      wr(SCD_ADDR_WAKE_EN, r[7:0]);
      {aux_en, aux, ex1, ex0, wdt} <= r[24:12];
      rd(SCD_ADDR_WAKE_EN, {5'h00, r[2:0]});
      chk(wake, (r[12] & r[2]) | (r[14] & r[1]) | (r[13] & r[0])
        | ((|r[23:15]) & r[24]));
    end
    results();
  end
endmodule
`default_nettype wire
